// >>> hdl/crtc_ext_pkg.sv
// constants for the extended display-controller register bank
// assumes an 8-bit index/data port pair driven synchronously to clock
package crtc_ext_pkg;
  // register indices
  localparam logic [7:0] IDX_DEVICE_ID_UPPER      = 8'h2D;
  localparam logic [7:0] IDX_DEVICE_ID_LOWER      = 8'h2E;
  localparam logic [7:0] IDX_SILICON_REVISION     = 8'h2F;
  localparam logic [7:0] IDX_LEGACY_PART_CODE     = 8'h30;
  localparam logic [7:0] IDX_MEMORY_CONFIGURATION = 8'h31;
  localparam logic [7:0] IDX_COMPAT_CONTROL_ONE   = 8'h32;
  localparam logic [7:0] IDX_COMPAT_CONTROL_TWO   = 8'h33;
  localparam logic [7:0] IDX_COMPAT_CONTROL_THREE = 8'h34;
  localparam logic [7:0] IDX_TIMING_REGISTER_LOCK = 8'h35;
  localparam logic [7:0] IDX_CONFIGURATION_ONE    = 8'h36;
  localparam logic [7:0] IDX_CONFIGURATION_TWO    = 8'h37;
  localparam logic [7:0] IDX_EXTENDED_UNLOCK_KEY  = 8'h38;
  localparam logic [7:0] IDX_SYSTEM_UNLOCK_KEY    = 8'h39;
  // locked ranges
  localparam logic [7:0] IDX_EXT_FIRST = 8'h30;
  localparam logic [7:0] IDX_EXT_LAST  = 8'h3C;
  localparam logic [7:0] IDX_SYS_FIRST = 8'h40;
  localparam logic [7:0] IDX_SYS_LAST  = 8'h6D;
  // reset values
  localparam logic [7:0] RESET_BYTE    = 8'h00;
  // field positions
  localparam int MC_BASE_OFFSET_EN = 0;
  localparam int MC_BUS16          = 2;
  localparam int MC_ENHANCED_MAP   = 3;
  localparam int MC_START_LO       = 4;
  localparam int MC_FONT_FETCH     = 6;
  localparam int C1_WRAP_256K      = 6;
  localparam int C1_VRAM_TRISTATE  = 7;
  localparam int C2_OVERFLOW_UNPROT = 1;
  localparam int C2_PIXCLK_INT     = 3;
  localparam int C2_CONV_WP        = 4;
  localparam int C2_BLANK_WHOLE    = 5;
  localparam int C2_PALETTE_WP     = 6;
  localparam int C3_SNOOP_METHOD   = 0;
  localparam int C3_NO_MABORT      = 1;
  localparam int C3_NO_RETRY       = 2;
  localparam int C3_XFER_POS_EN    = 4;
  localparam int TL_LOCK_VERT      = 4;
  localparam int TL_LOCK_HORIZ     = 5;
  localparam int CF1_MEM_TYPE_LO   = 2;
  localparam int CF1_MEM_SIZE_LO   = 5;
  localparam int CF1_BLOCK_WRITE8  = 7;
  localparam int CF2_TEST_MODE     = 1;
  localparam int CF2_INT_CLOCKS    = 3;
  localparam int CF2_DRAM_SIZE_LO  = 5;
  localparam int CF2_SCAN_TEST     = 7;
  localparam int SK_NO_READ_BURST  = 7;
endpackage : crtc_ext_pkg

// >>> hdl/extended_crtc_control_bank.sv
// extended display-controller register bank behind an index/data port
// assumes host index and write/read strobes arrive synchronous to clock
`timescale 1ns/1ps

// Functional notes
// - read-only upper identification byte; writes ignored
// - read-only lower identification byte; writes ignored
// - read-only revision byte, value may change between revisions
// - memory config bit 0 enables extended base address offset
// - memory config bit 2 selects 16-bit legacy memory bus
// - memory config bit 3 selects enhanced linear mapping
// - memory config bits 5-4 give start address bits 17-16
// - memory config bit 6 enables fast text font fetch
// - compat one bit 6 wraps legacy memory at 256K
// - compat one bit 7 floats vram serial clock, enable, function
// - compat two bit 1 cancels overflow register write protection
// - compat two bit 3 takes pixel clock from display clock
// - compat two bit 4 blocks colour converter port writes
// - compat two bit 5 blanks whole non-active period
// - compat two bit 6 blocks palette and overscan writes
// - compat three bits 0-2 pick snoop method, disable abort/retry
// - compat three bit 4 enables transfer execute position
// - timing lock bit 4 locks vertical, bit 5 horizontal
// - config one: memory type 3-2, size 6-5, block write bit 7
// - config two: internal clocks bit 3, test bit 1, scan bit 7
// - config two bits 6-5 give DRAM portion size
// - extended key must be written before indices 30-3C accept writes; the two key registers at 38 and 39 take writes without it
// - system key must be written before indices 40-6D accept writes; this bank holds no registers there and the key gates no writes
// - system key bit 7 forbids bus read bursts
module extended_crtc_control_bank #(
  parameter logic [7:0] DEVICE_ID_HIGH = 8'hA5, // arbitrary value
  parameter logic [7:0] DEVICE_ID_LOW  = 8'h5A, // arbitrary value
  parameter logic [7:0] REVISION       = 8'h01, // arbitrary value
  parameter logic [7:0] PART_CODE      = 8'hC3, // arbitrary value
  parameter logic [7:0] EXT_KEY        = 8'h48, // arbitrary value
  parameter logic [7:0] SYS_KEY        = 8'hA0  // arbitrary value
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // host index/data port
  input  wire logic [7:0] reg_index,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_write_data,
  input  wire logic       reg_read,
  output logic      [7:0] reg_read_data,
  output logic            reg_read_valid,
  // unlock status
  output logic            ext_unlocked,
  output logic            sys_unlocked,
  // memory configuration controls
  output logic            base_offset_enable,
  output logic            legacy_bus16,
  output logic            enhanced_mapping,
  output logic      [1:0] start_address_hi,
  output logic            font_fetch_fast,
  output logic            wrap_256k,
  output logic            vram_outputs_float,
  // compatibility controls
  output logic            overflow_unprotect,
  output logic            pixel_clock_internal,
  output logic            converter_write_block,
  output logic            blank_whole_period,
  output logic            palette_write_block,
  output logic            snoop_method,
  output logic            snoop_no_master_abort,
  output logic            snoop_no_retry,
  output logic            transfer_position_enable,
  output logic            lock_vertical_timing,
  output logic            lock_horizontal_timing,
  // configuration controls
  output logic      [1:0] memory_type,
  output logic      [1:0] memory_size,
  output logic            block_write8,
  output logic            test_mode,
  output logic            internal_clocks,
  output logic      [1:0] dram_portion_size,
  output logic            scan_test,
  output logic            read_burst_disable
);
  import crtc_ext_pkg::*;

  logic [7:0] memory_configuration;
  logic [7:0] compat_control_one;
  logic [7:0] compat_control_two;
  logic [7:0] compat_control_three;
  logic [7:0] timing_register_lock;
  logic [7:0] configuration_one;
  logic [7:0] configuration_two;
  logic [7:0] extended_unlock_key;
  logic [7:0] system_unlock_key;
  logic       ext_open;
  logic       write_ok;
  logic [7:0] next_read_data;

  //////////////////////////////////////////////////////////////////////////
  // extended group gate
  assign ext_open = (extended_unlock_key == EXT_KEY);
  // key registers themselves stay writable so software can unlock
  assign write_ok = reg_write
                  && ((reg_index == IDX_EXTENDED_UNLOCK_KEY)
                   || (reg_index == IDX_SYSTEM_UNLOCK_KEY) || ext_open);

  always_ff @(posedge clock) begin
    if (reset) begin
      extended_unlock_key <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_EXTENDED_UNLOCK_KEY)) begin
      extended_unlock_key <= reg_write_data;
    end
  end

  // system key store
  // keys stay writable at all times, else software could never unlock
  always_ff @(posedge clock) begin
    if (reset) begin
      system_unlock_key <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_SYSTEM_UNLOCK_KEY)) begin
      system_unlock_key <= reg_write_data;
    end
  end

  // identification bytes have no storage, so writes to them fall away;
  // control registers below take writes only while the extended key
  // matches, and a refused write is dropped without any sign at the port

  // memory configuration store
  always_ff @(posedge clock) begin
    if (reset) begin
      memory_configuration <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_MEMORY_CONFIGURATION)) begin
      memory_configuration <= reg_write_data;
    end
  end

  // compatibility one store
  always_ff @(posedge clock) begin
    if (reset) begin
      compat_control_one <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_COMPAT_CONTROL_ONE)) begin
      compat_control_one <= reg_write_data;
    end
  end

  // compatibility two store
  always_ff @(posedge clock) begin
    if (reset) begin
      compat_control_two <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_COMPAT_CONTROL_TWO)) begin
      compat_control_two <= reg_write_data;
    end
  end

  // compatibility three store
  always_ff @(posedge clock) begin
    if (reset) begin
      compat_control_three <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_COMPAT_CONTROL_THREE)) begin
      compat_control_three <= reg_write_data;
    end
  end

  // timing lock store
  always_ff @(posedge clock) begin
    if (reset) begin
      timing_register_lock <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_TIMING_REGISTER_LOCK)) begin
      timing_register_lock <= reg_write_data;
    end
  end

  // configuration one store
  always_ff @(posedge clock) begin
    if (reset) begin
      configuration_one <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_CONFIGURATION_ONE)) begin
      configuration_one <= reg_write_data;
    end
  end

  // configuration two store
  always_ff @(posedge clock) begin
    if (reset) begin
      configuration_two <= RESET_BYTE;
    end else if (write_ok && (reg_index == IDX_CONFIGURATION_TWO)) begin
      configuration_two <= reg_write_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read mux; unmapped indices read zero
  always_comb begin
    case (reg_index)
      IDX_DEVICE_ID_UPPER:      next_read_data = DEVICE_ID_HIGH;
      IDX_DEVICE_ID_LOWER:      next_read_data = DEVICE_ID_LOW;
      IDX_SILICON_REVISION:     next_read_data = REVISION;
      IDX_LEGACY_PART_CODE:     next_read_data = PART_CODE;
      IDX_MEMORY_CONFIGURATION: next_read_data = memory_configuration;
      IDX_COMPAT_CONTROL_ONE:   next_read_data = compat_control_one;
      IDX_COMPAT_CONTROL_TWO:   next_read_data = compat_control_two;
      IDX_COMPAT_CONTROL_THREE: next_read_data = compat_control_three;
      IDX_TIMING_REGISTER_LOCK: next_read_data = timing_register_lock;
      IDX_CONFIGURATION_ONE:    next_read_data = configuration_one;
      IDX_CONFIGURATION_TWO:    next_read_data = configuration_two;
      IDX_EXTENDED_UNLOCK_KEY:  next_read_data = extended_unlock_key;
      IDX_SYSTEM_UNLOCK_KEY:    next_read_data = system_unlock_key;
      default:                  next_read_data = 8'h00;
    endcase
  end

  // registered read answer, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_read_data  <= 8'h00;
      reg_read_valid <= 1'b0;
    end else begin
      reg_read_valid <= reg_read;
      if (reg_read)
        reg_read_data <= next_read_data;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registered control outputs; each lags its register by one cycle so
  // every output leaves a flip-flop, at the cost of one cycle of latency

  // mismatched key locks
  // status lags the key by one cycle; the next host access sees it
  always_ff @(posedge clock) begin
    if (reset) begin
      ext_unlocked <= RESET_BYTE[0];
      sys_unlocked <= RESET_BYTE[0];
    end else begin
      ext_unlocked <= ext_open;
      sys_unlocked <= (system_unlock_key == SYS_KEY);
    end
  end

  // memory configuration controls
  // start address bits feed only the legacy start-address path
  always_ff @(posedge clock) begin
    if (reset) begin
      base_offset_enable <= RESET_BYTE[0];
      legacy_bus16       <= RESET_BYTE[0];
      enhanced_mapping   <= RESET_BYTE[0];
      start_address_hi   <= RESET_BYTE[1:0];
      font_fetch_fast    <= RESET_BYTE[0];
    end else begin
      base_offset_enable <= memory_configuration[MC_BASE_OFFSET_EN];
      legacy_bus16 <= memory_configuration[MC_BUS16];
      enhanced_mapping <= memory_configuration[MC_ENHANCED_MAP];
      start_address_hi <= memory_configuration[MC_START_LO +: 2];
      font_fetch_fast <= memory_configuration[MC_FONT_FETCH];
    end
  end

  // compatibility one controls; the vram pads float outside this bank
  always_ff @(posedge clock) begin
    if (reset) begin
      wrap_256k          <= RESET_BYTE[0];
      vram_outputs_float <= RESET_BYTE[0];
    end else begin
      wrap_256k <= compat_control_one[C1_WRAP_256K];
      vram_outputs_float <= compat_control_one[C1_VRAM_TRISTATE];
    end
  end

  // compatibility two controls
  // write blocks only flag the palette and converter ports outside
  always_ff @(posedge clock) begin
    if (reset) begin
      overflow_unprotect    <= RESET_BYTE[0];
      pixel_clock_internal  <= RESET_BYTE[0];
      converter_write_block <= RESET_BYTE[0];
      blank_whole_period    <= RESET_BYTE[0];
      palette_write_block   <= RESET_BYTE[0];
    end else begin
      overflow_unprotect <= compat_control_two[C2_OVERFLOW_UNPROT];
      pixel_clock_internal <= compat_control_two[C2_PIXCLK_INT];
      converter_write_block <= compat_control_two[C2_CONV_WP];
      blank_whole_period <= compat_control_two[C2_BLANK_WHOLE];
      palette_write_block <= compat_control_two[C2_PALETTE_WP];
    end
  end

  // compatibility three controls
  // snoop bits steer bus handling that lives outside this bank
  always_ff @(posedge clock) begin
    if (reset) begin
      snoop_method             <= RESET_BYTE[0];
      snoop_no_master_abort    <= RESET_BYTE[0];
      snoop_no_retry           <= RESET_BYTE[0];
      transfer_position_enable <= RESET_BYTE[0];
    end else begin
      snoop_method          <= compat_control_three[C3_SNOOP_METHOD];
      snoop_no_master_abort <= compat_control_three[C3_NO_MABORT];
      snoop_no_retry        <= compat_control_three[C3_NO_RETRY];
      transfer_position_enable <= compat_control_three[C3_XFER_POS_EN];
    end
  end

  // timing locks only report; the timing registers sit outside
  always_ff @(posedge clock) begin
    if (reset) begin
      lock_vertical_timing   <= RESET_BYTE[0];
      lock_horizontal_timing <= RESET_BYTE[0];
    end else begin
      lock_vertical_timing   <= timing_register_lock[TL_LOCK_VERT];
      lock_horizontal_timing <= timing_register_lock[TL_LOCK_HORIZ];
    end
  end

  // configuration one controls
  // size and type only describe the memory; nothing here checks them
  always_ff @(posedge clock) begin
    if (reset) begin
      memory_type  <= RESET_BYTE[1:0];
      memory_size  <= RESET_BYTE[1:0];
      block_write8 <= RESET_BYTE[0];
    end else begin
      memory_type  <= configuration_one[CF1_MEM_TYPE_LO +: 2];
      memory_size  <= configuration_one[CF1_MEM_SIZE_LO +: 2];
      block_write8 <= configuration_one[CF1_BLOCK_WRITE8];
    end
  end

  // test and scan bits are plain storage; test logic sits outside
  always_ff @(posedge clock) begin
    if (reset) begin
      test_mode         <= RESET_BYTE[0];
      internal_clocks   <= RESET_BYTE[0];
      scan_test         <= RESET_BYTE[0];
      dram_portion_size <= RESET_BYTE[1:0];
    end else begin
      test_mode       <= configuration_two[CF2_TEST_MODE];
      internal_clocks <= configuration_two[CF2_INT_CLOCKS];
      scan_test       <= configuration_two[CF2_SCAN_TEST];
      dram_portion_size <= configuration_two[CF2_DRAM_SIZE_LO +: 2];
    end
  end

  // read burst inhibit
  // shares the key register, so every system key write moves it
  always_ff @(posedge clock) begin
    if (reset) begin
      read_burst_disable <= RESET_BYTE[0];
    end else begin
      read_burst_disable <= system_unlock_key[SK_NO_READ_BURST];
    end
  end
endmodule : extended_crtc_control_bank

// >>> verification/crtc_bank_assertions.sv
// port assertions for the extended register bank
// assumes one clock domain with synchronous active-high reset
`timescale 1ns/1ps
module crtc_bank_assertions #(
  parameter logic [7:0] DEVICE_ID_HIGH = 8'hA5,
  parameter logic [7:0] DEVICE_ID_LOW  = 8'h5A,
  parameter logic [7:0] REVISION       = 8'h01,
  parameter logic [7:0] EXT_KEY        = 8'h48,
  parameter logic [7:0] SYS_KEY        = 8'hA0
) (
  // clock, reset and host port
  input wire logic       clock,
  input wire logic       reset,
  input wire logic [7:0] reg_index,
  input wire logic       reg_write,
  input wire logic [7:0] reg_write_data,
  input wire logic       reg_read,
  input wire logic [7:0] reg_read_data,
  input wire logic       reg_read_valid,
  // watched controls
  input wire logic       ext_unlocked,
  input wire logic       sys_unlocked,
  input wire logic       base_offset_enable,
  input wire logic       enhanced_mapping,
  input wire logic [1:0] start_address_hi,
  input wire logic       wrap_256k,
  input wire logic       vram_outputs_float,
  input wire logic       read_burst_disable
);
  import crtc_ext_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic [7:0] data_d1;
  logic [7:0] data_d2;
  // write data two edges back, lined up with control updates
  always_ff @(posedge clock) begin
    data_d1 <= reg_write_data;
    data_d2 <= data_d1;
  end
  ////////////////////////////////////////////////////////////
  sequence rd_at(logic [7:0] i); reg_read && reg_index == i; endsequence
  sequence wr_at(logic [7:0] i); reg_write && reg_index == i; endsequence
  sequence open_wr(logic [7:0] i); ext_unlocked ##0 wr_at(i); endsequence
  sequence shut_wr(logic [7:0] i); !ext_unlocked ##0 wr_at(i); endsequence
  a_upper_id_read: assert property (rd_at(IDX_DEVICE_ID_UPPER) |=>
    reg_read_valid && reg_read_data == DEVICE_ID_HIGH)
    else $error("upper id byte read wrong");
  a_lower_id_read: assert property (rd_at(IDX_DEVICE_ID_LOWER) |=>
    reg_read_valid && reg_read_data == DEVICE_ID_LOW)
    else $error("lower id byte read wrong");
  a_revision_read: assert property (rd_at(IDX_SILICON_REVISION) |=>
    reg_read_valid && reg_read_data == REVISION)
    else $error("revision byte read wrong");
  a_ext_key_open: assert property (wr_at(IDX_EXTENDED_UNLOCK_KEY)
    ##0 reg_write_data == EXT_KEY |=> ##1 ext_unlocked)
    else $error("extended group not opened by key");
  a_ext_key_shut: assert property (wr_at(IDX_EXTENDED_UNLOCK_KEY)
    ##0 reg_write_data != EXT_KEY |=> ##1 !ext_unlocked)
    else $error("extended group open on wrong key");
  a_sys_key_match: assert property (wr_at(IDX_SYSTEM_UNLOCK_KEY)
    |=> ##1 sys_unlocked == (data_d2 == SYS_KEY))
    else $error("system unlock does not follow key");
  a_burst_bit_follow: assert property (wr_at(IDX_SYSTEM_UNLOCK_KEY)
    |=> ##1 read_burst_disable == data_d2[7])
    else $error("read burst disable not key bit 7");
  a_mapping_follow: assert property (open_wr(IDX_MEMORY_CONFIGURATION)
    |=> ##1 enhanced_mapping == data_d2[3] && base_offset_enable ==
    data_d2[0] && start_address_hi == data_d2[5:4])
    else $error("memory configuration controls wrong");
  a_compat_follow: assert property (open_wr(IDX_COMPAT_CONTROL_ONE)
    |=> ##1 wrap_256k == data_d2[6] && vram_outputs_float == data_d2[7])
    else $error("compatibility one controls wrong");
  a_locked_hold: assert property (shut_wr(IDX_MEMORY_CONFIGURATION)
    |=> ##1 $stable({enhanced_mapping, base_offset_enable, start_address_hi}))
    else $error("locked memory configuration changed");
endmodule : crtc_bank_assertions

bind extended_crtc_control_bank crtc_bank_assertions #(
  .DEVICE_ID_HIGH(DEVICE_ID_HIGH), .DEVICE_ID_LOW(DEVICE_ID_LOW),
  .REVISION(REVISION), .EXT_KEY(EXT_KEY), .SYS_KEY(SYS_KEY)
) u_checker (.clock, .reset, .reg_index, .reg_write, .reg_write_data,
  .reg_read, .reg_read_data, .reg_read_valid, .ext_unlocked, .sys_unlocked,
  .base_offset_enable, .enhanced_mapping, .start_address_hi, .wrap_256k,
  .vram_outputs_float, .read_burst_disable);

// >>> verification/crtc_host_model.sv
// host model driving the index/data port of the register bank
// assumes the bank takes strobes on the rising clock edge
`timescale 1ns/1ps
module crtc_host_model (
  // clock
  input  wire logic       clock,
  // port toward the bank
  output logic      [7:0] reg_index,
  output logic            reg_write,
  output logic      [7:0] reg_write_data,
  output logic            reg_read,
  input  wire logic [7:0] reg_read_data,
  input  wire logic       reg_read_valid
);
  // idle port at time zero
  initial begin
    reg_index = 8'h00;
    reg_write = 1'b0;
    reg_write_data = 8'h00;
    reg_read = 1'b0;
  end
  // one-cycle strobe, never re-raised in the same time step
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_index = a;
    reg_write_data = d;
    reg_write = 1'b1;
    @(negedge clock);
    reg_write = 1'b0;
    reg_write_data = ~d; // stale data must not pass as valid
  endtask : write_reg
  // bounded wait so a dead valid cannot hang the run
  task automatic read_reg(input logic [7:0] a, output logic [7:0] q);
    int n;
    @(negedge clock);
    reg_index = a;
    reg_read = 1'b1;
    @(negedge clock);
    reg_read = 1'b0;
    for (n = 0; n < 4 && reg_read_valid !== 1'b1; n++) @(negedge clock);
    q = reg_read_data;
  endtask : read_reg
endmodule : crtc_host_model

// >>> verification/extended_crtc_control_bank_tb.sv
// self-checking bench for the extended register bank
// assumes the host model drives the port on falling edges
`timescale 1ns/1ps
module extended_crtc_control_bank_tb;
  localparam logic [7:0] EKEY = 8'h48;
  localparam logic [7:0] SKEY = 8'hA0;
  logic       clock, reset, reg_write, reg_read, reg_read_valid;
  logic [7:0] reg_index, reg_write_data, reg_read_data, rd, idx, dat;
  logic       ext_unlocked, sys_unlocked, base_offset_enable, legacy_bus16;
  logic       enhanced_mapping, font_fetch_fast, wrap_256k, scan_test;
  logic       vram_outputs_float, overflow_unprotect, pixel_clock_internal;
  logic       converter_write_block, blank_whole_period, snoop_method;
  logic       palette_write_block, snoop_no_master_abort, snoop_no_retry;
  logic       transfer_position_enable, lock_vertical_timing, test_mode;
  logic       lock_horizontal_timing, block_write8, internal_clocks;
  logic       read_burst_disable;
  logic [1:0] start_address_hi, memory_type, memory_size, dram_portion_size;
  logic [7:0] m [0:255]; // register mirror
  int         num_errors, compares, seed, i;
  crtc_host_model host (.clock, .reg_index, .reg_write, .reg_write_data,
    .reg_read, .reg_read_data, .reg_read_valid);
  extended_crtc_control_bank DUT (.clock, .reset, .reg_index, .reg_write,
    .reg_write_data, .reg_read, .reg_read_data, .reg_read_valid,
    .ext_unlocked, .sys_unlocked, .base_offset_enable, .legacy_bus16,
    .enhanced_mapping, .start_address_hi, .font_fetch_fast, .wrap_256k,
    .vram_outputs_float, .overflow_unprotect, .pixel_clock_internal,
    .converter_write_block, .blank_whole_period, .palette_write_block,
    .snoop_method, .snoop_no_master_abort, .snoop_no_retry,
    .transfer_position_enable, .lock_vertical_timing,
    .lock_horizontal_timing, .memory_type, .memory_size, .block_write8,
    .test_mode, .internal_clocks, .dram_portion_size, .scan_test,
    .read_burst_disable);
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  // all controls against the mirror, one edge after the store
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d);
    if (a == 8'h38 || a == 8'h39 || (a > 8'h30 && a < 8'h38 &&
        m[8'h38] == EKEY)) m[a] = d;
    @(negedge clock);
    check({ext_unlocked, sys_unlocked, base_offset_enable, legacy_bus16,
      enhanced_mapping, start_address_hi, font_fetch_fast, wrap_256k,
      vram_outputs_float, overflow_unprotect, pixel_clock_internal,
      converter_write_block, blank_whole_period, palette_write_block,
      snoop_method, snoop_no_master_abort, snoop_no_retry,
      transfer_position_enable, lock_vertical_timing,
      lock_horizontal_timing, memory_type, memory_size, block_write8,
      test_mode, internal_clocks, dram_portion_size, scan_test,
      read_burst_disable}, {m[8'h38] == EKEY, m[8'h39] == SKEY,
      m[8'h31][0], m[8'h31][2], m[8'h31][3], m[8'h31][5:4], m[8'h31][6],
      m[8'h32][6], m[8'h32][7],
      m[8'h33][1], m[8'h33][3], m[8'h33][4], m[8'h33][5], m[8'h33][6],
      m[8'h34][0], m[8'h34][1], m[8'h34][2],
      m[8'h34][4], m[8'h35][4], m[8'h35][5], m[8'h36][3:2], m[8'h36][6:5],
      m[8'h36][7], m[8'h37][1], m[8'h37][3], m[8'h37][6:5], m[8'h37][7],
      m[8'h39][7]});
  endtask : wr
  task automatic rd_chk(input logic [7:0] a);
    logic [7:0] e;
    e = (a > 8'h30 && a < 8'h3A) ? m[a] : 8'h00;
    if (a == 8'h2D) e = 8'hA5;
    if (a == 8'h2E) e = 8'h5A;
    if (a == 8'h2F) e = 8'h01;
    if (a == 8'h30) e = 8'hC3;
    host.read_reg(a, rd);
    check({24'h000000, rd}, {24'h000000, e});
    check({31'h0, reg_read_valid}, 32'h1);
  endtask : rd_chk
  task automatic end_of_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  ////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // generous bound over roughly 480 cycles of traffic
  initial begin
    #80000;
    num_errors++;
    $display("BAD %0t timeout", $time);
    end_of_test();
  end
  initial begin
    seed = 69348;
    num_errors = 0;
    compares = 0;
    for (i = 0; i < 256; i++) m[i] = 8'h00;
    reset = 1'b1;
    repeat (5) @(negedge clock);
    reset = 1'b0;
    // reset values, identity bytes and an unmapped index
    for (i = 8'h2C; i < 8'h3B; i++) rd_chk(8'(i));
    rd_chk(8'hFF);
    // locked writes, a near-miss key, then the real key
    for (i = 8'h2D; i < 8'h38; i++) wr(8'(i), 8'hFF);
    wr(8'h38, EKEY ^ 8'h01);
    wr(8'h31, 8'hFF);
    wr(8'h38, EKEY);
    // random bytes with keys mixed in, read back each time
    for (i = 0; i < 80; i++) begin
      idx = 8'h2D + 8'(($random(seed) & 15) % 13);
      dat = 8'($random(seed));
      if (idx == 8'h38 && dat[0]) dat = EKEY;
      if (idx == 8'h39 && dat[0]) dat = SKEY;
      wr(idx, dat);
      rd_chk(idx);
    end
    wr(8'h39, SKEY);
    wr(8'h39, 8'h80);
    end_of_test();
  end
endmodule : extended_crtc_control_bank_tb
